// ==== hdl/ttc_tracker.v ====
`timescale 1ns/1ps
`include "ttc_defs.vh"

// How it works
// - wake input forces sleep to wake
// - wake threshold and hysteresis from settings
// - low power uses low-power angle path
// - source select 1 uses full-power path outside low power
// - source select 0 uses only low-power path
// - leaving low power returns to full path if source select is 1
// - total is 12-bit angle plus turns
// - upper word read freezes lower word
// - upper at 0x36, lower at 0x38
// - negative totals in two's complement
// - start value chosen by start-up field
// - turns output is total's upper bits
// - 45-degree mode saturates 2047 / -2048
// - 180-degree mode saturates 511 / -512
// - sticky overflow until reset command
// - periodic low power samples add deltas
// - delta of 180 deg or more reverses
// - delta above 135 deg sets warning
// - sleep ends on timer or wake input
// - counter cleared by special command
module ttc_tracker
#(
  parameter LFO_DIV = `TTC_LFO_DIV
)
(
  // clock and reset
  input  wire                       clk,
  input  wire                       rstn,
  // angle paths
  input  wire [`TTC_PART_W-1:0]     fp_angle,
  input  wire                       fp_angle_valid,
  input  wire [`TTC_PART_W-1:0]     lp_angle,
  input  wire                       lp_angle_valid,
  // power state
  input  wire                       low_power_mode,
  input  wire                       sleep_request,
  input  wire [7:0]                 wake_level,
  // nonvolatile settings
  input  wire [7:0]                 wakeup_input_threshold,
  input  wire [1:0]                 wakeup_input_hysteresis,
  input  wire                       count_source_select,
  input  wire [1:0]                 turns_init,
  input  wire                       mode_180,
  input  wire [`TTC_SLEEP_CNT_W-1:0] sleep_period_length,
  // control register special command
  input  wire                       counter_reset_cmd,
  // register read port
  input  wire                       rd_strobe,
  input  wire [`TTC_ADDR_W-1:0]     rd_addr,
  output reg  [`TTC_WORD_W-1:0]     rd_data_ff,
  output reg                        rd_valid_ff,
  // status
  output reg  [`TTC_PART_W-1:0]     turns_count_ff,
  output reg                        overflow_flag_ff,
  output reg                        warning_flag_ff,
  output reg                        sleeping_ff,
  output reg                        lp_sample_req_ff
);

  localparam ST_WAKE  = 1'b0;
  localparam ST_SLEEP = 1'b1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // wrap-around difference; a 12-bit two's complement result turns any
  // step of half a turn or more into a step the other way
  function [`TTC_PART_W-1:0] ang_delta;
    input [`TTC_PART_W-1:0] cur;
    input [`TTC_PART_W-1:0] prev;
    begin
      ang_delta = cur - prev;
    end
  endfunction

  function [`TTC_PART_W-1:0] mag12;
    input [`TTC_PART_W-1:0] v;
    begin
      mag12 = v[`TTC_PART_W-1] ? (~v + 12'h001) : v;
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [`TTC_TOTAL_W-1:0]      total_ff;
  reg  [`TTC_TOTAL_W-1:0]      nxt_total;
  reg  [`TTC_PART_W-1:0]       prev_angle_ff;
  reg  [`TTC_PART_W-1:0]       nxt_prev_angle;
  reg                          started_ff;
  reg                          nxt_started;
  reg  [`TTC_PART_W-1:0]       lower_lock_ff;
  reg  [`TTC_PART_W-1:0]       nxt_lower_lock;
  reg                          nxt_overflow;
  reg                          nxt_warning;
  reg  [15:0]                  lfo_div_ff;
  reg                          lfo_tick_ff;
  reg  [`TTC_SLEEP_CNT_W-1:0]  sleep_cnt_ff;
  reg  [`TTC_SLEEP_CNT_W-1:0]  nxt_sleep_cnt;
  reg                          state_ff;
  reg                          nxt_state;
  reg                          nxt_lp_req;
  wire                         wake_active;

  // ----------------------------------------------------------------
  // wake input comparator
  // ----------------------------------------------------------------
  ttc_wake_detect u_wake
  (
    .clk                     (clk),
    .rstn                    (rstn),
    .wake_level              (wake_level),
    .wakeup_input_threshold  (wakeup_input_threshold),
    .wakeup_input_hysteresis (wakeup_input_hysteresis),
    .wake_active_ff          (wake_active)
  );

  // ----------------------------------------------------------------
  // low frequency tick divider
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lfo_div_ff  <= 16'h0000;
      lfo_tick_ff <= 1'b0;
    end
    else if (lfo_div_ff >= LFO_DIV[15:0] - 16'h0001)
    begin
      lfo_div_ff  <= 16'h0000;
      lfo_tick_ff <= 1'b1;
    end
    else
    begin
      lfo_div_ff  <= lfo_div_ff + 16'h0001;
      lfo_tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sleep / wake sequencing inside low power mode
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_state     = state_ff;
    nxt_sleep_cnt = sleep_cnt_ff;
    nxt_lp_req    = 1'b0;
    case (state_ff)
      ST_WAKE:
      begin
        nxt_sleep_cnt = {`TTC_SLEEP_CNT_W{1'b0}};
        // the wake input holds the sensor awake
        if (low_power_mode && sleep_request && !wake_active)
          nxt_state = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (lfo_tick_ff)
          nxt_sleep_cnt = sleep_cnt_ff + 1'b1;
        if (!low_power_mode || wake_active)
        begin
          nxt_state  = ST_WAKE;
          nxt_lp_req = low_power_mode;
        end
        else if (lfo_tick_ff &&
                 nxt_sleep_cnt >= sleep_period_length)
        begin
          nxt_state  = ST_WAKE;
          nxt_lp_req = 1'b1;
        end
      end
      default:
      begin
        nxt_state = ST_WAKE;
      end
    endcase
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff         <= ST_WAKE;
      sleep_cnt_ff     <= {`TTC_SLEEP_CNT_W{1'b0}};
      sleeping_ff      <= 1'b0;
      lp_sample_req_ff <= 1'b0;
    end
    else
    begin
      state_ff         <= nxt_state;
      sleep_cnt_ff     <= nxt_sleep_cnt;
      sleeping_ff      <= (nxt_state == ST_SLEEP);
      lp_sample_req_ff <= nxt_lp_req;
    end
  end

  // ----------------------------------------------------------------
  // angle source selection and accumulation
  // ----------------------------------------------------------------
  reg                      use_fp;
  reg                      src_valid;
  reg  [`TTC_PART_W-1:0]   src_angle;
  reg  [`TTC_PART_W-1:0]   delta;
  reg  [`TTC_TOTAL_W:0]    sum;
  reg  [`TTC_PART_W:0]     sum_turns;
  reg  [`TTC_PART_W-1:0]   t_max;
  reg  [`TTC_PART_W-1:0]   t_min;
  reg                      over_hi;
  reg                      over_lo;
  reg                      set_ovf;
  reg                      set_warn;

  always @*
  begin
    // low power always counts on the low-power path; back in full
    // power the accurate path takes over when the setting allows
    use_fp = !low_power_mode && count_source_select;
    src_valid = use_fp ? fp_angle_valid : lp_angle_valid;
    src_angle = use_fp ? fp_angle : lp_angle;
    t_max = mode_180 ? `TTC_TURNS_MAX_180 : `TTC_TURNS_MAX_45;
    t_min = mode_180 ? `TTC_TURNS_MIN_180 : `TTC_TURNS_MIN_45;
    delta = ang_delta(src_angle, prev_angle_ff);
    // sign-extended add keeps negative totals in two's complement
    sum = {total_ff[`TTC_TOTAL_W-1], total_ff} +
          {{(`TTC_TOTAL_W-`TTC_PART_W+1){delta[`TTC_PART_W-1]}},
           delta};
    sum_turns = sum[`TTC_TOTAL_W:`TTC_PART_W];
    over_hi = !sum_turns[`TTC_PART_W] &&
              ($signed(sum_turns) >
               $signed({t_max[`TTC_PART_W-1], t_max}));
    over_lo = sum_turns[`TTC_PART_W] &&
              ($signed(sum_turns) <
               $signed({t_min[`TTC_PART_W-1], t_min}));
    set_ovf  = 1'b0;
    set_warn = 1'b0;
    nxt_total      = total_ff;
    nxt_prev_angle = prev_angle_ff;
    nxt_started    = started_ff;
    if (counter_reset_cmd)
    begin
      nxt_total = `TTC_TOTAL_RST;
      if (src_valid)
        nxt_prev_angle = src_angle;
    end
    else if (src_valid && !started_ff)
    begin
      nxt_started    = 1'b1;
      nxt_prev_angle = src_angle;
      if (turns_init == `TTC_INIT_ZERO)
        nxt_total = `TTC_TOTAL_RST;
      else
        nxt_total = {{(`TTC_TOTAL_W-`TTC_PART_W){1'b0}}, src_angle};
    end
    else if (src_valid)
    begin
      nxt_prev_angle = src_angle;
      set_warn = (mag12(delta) > `TTC_DELTA_WARN);
      // one lsb of the total is one angle step of 360/4096 degree
      if (over_hi)
      begin
        nxt_total = {t_max, `TTC_ANGLE_FULL};
        set_ovf   = 1'b1;
      end
      else if (over_lo)
      begin
        nxt_total = {t_min, {`TTC_PART_W{1'b0}}};
        set_ovf   = 1'b1;
      end
      else
      begin
        nxt_total = sum[`TTC_TOTAL_W-1:0];
      end
    end
    // the reset command clears both flags; neither can be raised in its cycle
    nxt_overflow = set_ovf ||
                   (overflow_flag_ff && !counter_reset_cmd);
    nxt_warning  = set_warn ||
                   (warning_flag_ff && !counter_reset_cmd);
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      total_ff         <= `TTC_TOTAL_RST;
      prev_angle_ff    <= {`TTC_PART_W{1'b0}};
      started_ff       <= 1'b0;
      overflow_flag_ff <= 1'b0;
      warning_flag_ff  <= 1'b0;
      turns_count_ff   <= {`TTC_PART_W{1'b0}};
    end
    else
    begin
      total_ff         <= nxt_total;
      prev_angle_ff    <= nxt_prev_angle;
      started_ff       <= nxt_started;
      overflow_flag_ff <= nxt_overflow;
      warning_flag_ff  <= nxt_warning;
      turns_count_ff   <= nxt_total[`TTC_TOTAL_W-1:`TTC_PART_W];
    end
  end

  // ----------------------------------------------------------------
  // register reads with upper-then-lower coherence
  // ----------------------------------------------------------------
  reg  [`TTC_WORD_W-1:0] nxt_rd_data;

  always @*
  begin
    nxt_lower_lock = lower_lock_ff;
    nxt_rd_data    = `TTC_WORD_RST;
    if (rd_strobe)
    begin
      case (rd_addr)
        `TTC_ADDR_POS_UPPER:
        begin
          nxt_rd_data = {overflow_flag_ff, warning_flag_ff, 2'h0,
                         total_ff[`TTC_TOTAL_W-1:`TTC_PART_W]};
          // the lower half is frozen from the same sample
          nxt_lower_lock = total_ff[`TTC_PART_W-1:0];
        end
        `TTC_ADDR_POS_LOWER:
        begin
          nxt_rd_data = {4'h0, lower_lock_ff};
        end
        default:
        begin
          nxt_rd_data = `TTC_WORD_RST;
        end
      endcase
    end
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lower_lock_ff <= {`TTC_PART_W{1'b0}};
      rd_data_ff    <= `TTC_WORD_RST;
      rd_valid_ff   <= 1'b0;
    end
    else
    begin
      lower_lock_ff <= nxt_lower_lock;
      rd_data_ff    <= nxt_rd_data;
      rd_valid_ff   <= rd_strobe;
    end
  end

endmodule

// ==== hdl/ttc_defs.vh ====
`ifndef TTC_DEFS_VH
`define TTC_DEFS_VH

// ----------------------------------------------------------------
// register map (byte addresses on the serial register space)
// ----------------------------------------------------------------
`define TTC_ADDR_POS_UPPER   8'h36
`define TTC_ADDR_POS_LOWER   8'h38
`define TTC_ADDR_W           8

// ----------------------------------------------------------------
// field layout of the position words
// ----------------------------------------------------------------
`define TTC_PART_W           12
`define TTC_TOTAL_W          24
`define TTC_WORD_W           16
`define TTC_UPPER_OVF_BIT    15
`define TTC_UPPER_WARN_BIT   14

// ----------------------------------------------------------------
// start-up selection codes
// ----------------------------------------------------------------
`define TTC_INIT_ZERO        2'h0
`define TTC_INIT_ANGLE       2'h1

// ----------------------------------------------------------------
// revolution limits, one lsb = 360/4096 degree of the total
// ----------------------------------------------------------------
`define TTC_TURNS_MAX_45     12'h7FF
`define TTC_TURNS_MIN_45     12'h800
`define TTC_TURNS_MAX_180    12'h1FF
`define TTC_TURNS_MIN_180    12'hE00
`define TTC_DELTA_WARN       12'h600
`define TTC_ANGLE_FULL       12'hFFF

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define TTC_TOTAL_RST        24'h000000
`define TTC_WORD_RST         16'h0000
`define TTC_SLEEP_CNT_W      16
`define TTC_LFO_DIV          16'h0064
`define TTC_HYS_SHIFT        2

`endif

// ==== hdl/ttc_wake_detect.v ====
`timescale 1ns/1ps
`include "ttc_defs.vh"

// comparator with programmable hysteresis on the sampled wake input
module ttc_wake_detect
(
  // clock and reset
  input  wire       clk,
  input  wire       rstn,
  // sampled wake input level and settings
  input  wire [7:0] wake_level,
  input  wire [7:0] wakeup_input_threshold,
  input  wire [1:0] wakeup_input_hysteresis,
  // result
  output reg        wake_active_ff
);

  reg  [9:0] hys_span;
  reg        nxt_wake_active;

  always @*
  begin
    hys_span = {6'h00, wakeup_input_hysteresis, 2'h0};
    nxt_wake_active = wake_active_ff;
    // releasing below threshold minus span keeps a slow edge from chattering
    if (!wake_active_ff)
    begin
      if ({2'h0, wake_level} >= {2'h0, wakeup_input_threshold})
        nxt_wake_active = 1'b1;
    end
    else if ({2'h0, wake_level} + hys_span <
             {2'h0, wakeup_input_threshold})
    begin
      nxt_wake_active = 1'b0;
    end
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wake_active_ff <= 1'b0;
    else
      wake_active_ff <= nxt_wake_active;
  end

endmodule

// ==== test/ttc_tracker_sva.sv ====
`timescale 1ns/1ps
module ttc_chk
(
  // clock and reset
  input wire        clk,
  input wire        rstn,
  // stimulus side
  input wire        rd_strobe,
  input wire [7:0]  rd_addr,
  input wire        counter_reset_cmd,
  input wire        mode_180,
  input wire        low_power_mode,
  // design outputs
  input wire [15:0] rd_data_ff,
  input wire        rd_valid_ff,
  input wire [11:0] turns_count_ff,
  input wire        overflow_flag_ff,
  input wire        warning_flag_ff,
  input wire        sleeping_ff,
  input wire        lp_sample_req_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_RD_ANSWER: assert property (rd_strobe |=> rd_valid_ff)
    else $error("read not answered");
  AST_IDLE_DATA: assert property (!rd_valid_ff |-> rd_data_ff == 16'h0000)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (rd_strobe && rd_addr != 8'h36 &&
    rd_addr != 8'h38 |=> rd_data_ff == 16'h0000)
    else $error("unmapped read not zero");
  AST_UPPER: assert property (rd_strobe && rd_addr == 8'h36 |=>
    rd_data_ff == {$past(overflow_flag_ff), $past(warning_flag_ff),
    2'h0, $past(turns_count_ff)})
    else $error("upper word wrong");
  AST_OVF_HOLD: assert property (overflow_flag_ff &&
    !counter_reset_cmd |=> overflow_flag_ff)
    else $error("overflow flag dropped");
  AST_WARN_HOLD: assert property (warning_flag_ff &&
    !counter_reset_cmd |=> warning_flag_ff)
    else $error("warning flag dropped");
  AST_CLEAR: assert property (counter_reset_cmd |=>
    turns_count_ff == 12'h000)
    else $error("turns not cleared");
  AST_LIM180: assert property (mode_180 |->
    $signed(turns_count_ff) <= $signed(12'h1FF) &&
    $signed(turns_count_ff) >= $signed(12'hE00))
    else $error("turns beyond 180 mode limits");
  AST_WAKE_PULSE: assert property (lp_sample_req_ff |->
    $fell(sleeping_ff))
    else $error("sample request without wake");
  AST_SLEEP_LP: assert property ($rose(sleeping_ff) |->
    $past(low_power_mode))
    else $error("sleep outside low power");
endmodule

bind ttc_tracker ttc_chk ttc_chk_inst
(
  .clk(clk), .rstn(rstn), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
  .counter_reset_cmd(counter_reset_cmd), .mode_180(mode_180),
  .low_power_mode(low_power_mode), .rd_data_ff(rd_data_ff),
  .rd_valid_ff(rd_valid_ff), .turns_count_ff(turns_count_ff),
  .overflow_flag_ff(overflow_flag_ff), .warning_flag_ff(warning_flag_ff),
  .sleeping_ff(sleeping_ff), .lp_sample_req_ff(lp_sample_req_ff)
);

// ==== test/ttc_host.sv ====
`timescale 1ns/1ps
module ttc_host
(
  // clock
  input  wire        clk,
  // read port
  output reg         rd_strobe,
  output reg  [7:0]  rd_addr,
  input  wire [15:0] rd_data_ff,
  input  wire        rd_valid_ff
);
  initial
  begin
    rd_strobe = 1'b0;
    rd_addr   = 8'hA5;
  end

  // idle address is scrambled so a stale value never helps
  task rd(input [7:0] a, output [15:0] d);
  begin
    @(negedge clk);
    rd_strobe = 1'b1;
    rd_addr   = a;
    @(negedge clk);
    d         = rd_valid_ff ? rd_data_ff : 16'hBAD0;
    rd_strobe = 1'b0;
    rd_addr   = ~a;
  end
  endtask

  task pos(output [23:0] t, output [15:0] up);
    reg [15:0] lo;
  begin
    rd(8'h36, up);
    rd(8'h38, lo);
    t = {up[11:0], lo[11:0]};
  end
  endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  reg         clk;
  reg         rstn;
  reg  [11:0] fp_angle;
  reg         fp_angle_valid;
  reg  [11:0] lp_angle;
  reg         lp_angle_valid;
  reg         low_power_mode;
  reg         sleep_request;
  reg  [7:0]  wake_level;
  reg         count_source_select;
  reg  [1:0]  turns_init;
  reg         mode_180;
  reg  [15:0] sleep_period_length;
  reg         counter_reset_cmd;
  reg         req_seen;
  reg  [23:0] tot;
  reg  [15:0] w;
  wire        rd_strobe;
  wire [7:0]  rd_addr;
  wire [15:0] rd_data_ff;
  wire        rd_valid_ff;
  wire [11:0] turns_count_ff;
  wire        overflow_flag_ff;
  wire        warning_flag_ff;
  wire        sleeping_ff;
  wire        lp_sample_req_ff;
  integer     error_cnt;
  integer     checks_done;

  // ----------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------
  ttc_tracker #(.LFO_DIV(4)) ttc_tracker_inst
  (
    .clk(clk), .rstn(rstn), .fp_angle(fp_angle),
    .fp_angle_valid(fp_angle_valid), .lp_angle(lp_angle),
    .lp_angle_valid(lp_angle_valid), .low_power_mode(low_power_mode),
    .sleep_request(sleep_request), .wake_level(wake_level),
    .wakeup_input_threshold(8'h80), .wakeup_input_hysteresis(2'h1),
    .count_source_select(count_source_select), .turns_init(turns_init),
    .mode_180(mode_180), .sleep_period_length(sleep_period_length),
    .counter_reset_cmd(counter_reset_cmd), .rd_strobe(rd_strobe),
    .rd_addr(rd_addr), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff),
    .turns_count_ff(turns_count_ff), .overflow_flag_ff(overflow_flag_ff),
    .warning_flag_ff(warning_flag_ff), .sleeping_ff(sleeping_ff),
    .lp_sample_req_ff(lp_sample_req_ff)
  );
  ttc_host ttc_host_inst
  (
    .clk(clk), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff)
  );

  always #5 clk = ~clk;
  // caught on the pulse itself, so a check made at that negedge sees it
  always @(posedge lp_sample_req_ff)
    if (lp_sample_req_ff === 1'b1)
      req_seen = 1'b1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input [24:0] got, input [24:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task do_rst;
  begin
    @(negedge clk);
    rstn = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
  end
  endtask

  // one sample on the full (f=1) or low-power path
  task smp(input f, input [11:0] a);
  begin
    @(negedge clk);
    fp_angle       = a;
    lp_angle       = a;
    fp_angle_valid = f;
    lp_angle_valid = !f;
    @(negedge clk);
    fp_angle_valid = 1'b0;
    lp_angle_valid = 1'b0;
  end
  endtask

  task pos_chk(input [24:0] exp);
  begin
    ttc_host_inst.pos(tot, w);
    chk({w[14], tot}, exp);
    chk({13'h0, turns_count_ff}, {13'h0, exp[23:12]});
    chk({24'h0, warning_flag_ff}, {24'h0, exp[24]});
  end
  endtask

  task wslp(input v, input integer n);
    integer i;
  begin
    i = 0;
    while (sleeping_ff !== v && i < n)
    begin
      @(negedge clk);
      i = i + 1;
    end
    chk({24'h0, sleeping_ff}, {24'h0, v});
  end
  endtask

  task conclude;
  begin
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_track;
  begin
    turns_init          = 2'h2;
    count_source_select = 1'b0;
    do_rst;
    pos_chk(25'h0);
    ttc_host_inst.rd(8'h3A, w);
    chk({9'h0, w}, 25'h0);
    smp(0, 12'hABC);
    smp(1, 12'h123);
    pos_chk(25'h000ABC);
    smp(0, 12'h0BC);
    pos_chk(25'h0010BC);
    smp(0, 12'h6BD);
    pos_chk(25'h10016BD);
    smp(0, 12'hEBD);
    pos_chk(25'h1000EBD);
    ttc_host_inst.rd(8'h36, w);
    smp(0, 12'h6BE);
    ttc_host_inst.rd(8'h38, w);
    chk({9'h0, w}, 25'h0EBD);
    pos_chk(25'h10006BE);
    $display("track done");
  end
  endtask

  task t_paths;
  begin
    turns_init          = 2'h0;
    count_source_select = 1'b1;
    do_rst;
    smp(1, 12'h100);
    pos_chk(25'h0);
    smp(1, 12'h000);
    smp(0, 12'h400);
    pos_chk(25'hFFFF00);
    low_power_mode = 1'b1;
    smp(1, 12'h800);
    smp(0, 12'hF80);
    pos_chk(25'hFFFE80);
    low_power_mode = 1'b0;
    smp(0, 12'h400);
    smp(1, 12'hF00);
    pos_chk(25'hFFFE00);
    $display("paths done");
  end
  endtask

  // drives the total into a limit with a sample every cycle
  task t_sat(input m, input [24:0] exp);
    integer i;
  begin
    mode_180            = m;
    turns_init          = 2'h0;
    count_source_select = 1'b0;
    do_rst;
    for (i = 0; i < 4200; i = i + 1)
    begin
      @(negedge clk);
      lp_angle_valid = 1'b1;
      lp_angle       = m ? lp_angle + 12'h7FF : lp_angle - 12'h7FF;
    end
    @(negedge clk);
    lp_angle_valid = 1'b0;
    ttc_host_inst.pos(tot, w);
    chk({w[15], tot}, exp);
    chk({24'h0, overflow_flag_ff}, {24'h0, exp[24]});
    @(negedge clk);
    counter_reset_cmd = 1'b1;
    @(negedge clk);
    counter_reset_cmd = 1'b0;
    ttc_host_inst.pos(tot, w);
    chk({w[15], tot}, 25'h0);
    chk({24'h0, overflow_flag_ff}, 25'h0);
    $display("saturation done");
  end
  endtask

  task t_sleep;
  begin
    low_power_mode      = 1'b1;
    sleep_request       = 1'b1;
    sleep_period_length = 16'h0003;
    req_seen            = 1'b0;
    wslp(1, 10);
    wslp(0, 24);
    chk({24'h0, req_seen}, 25'h1);
    sleep_period_length = 16'hFFFF;
    wslp(1, 10);
    wake_level = 8'h7F;
    repeat (10) @(negedge clk);
    chk({24'h0, sleeping_ff}, 25'h1);
    wake_level = 8'h80;
    wslp(0, 4);
    // inside the hysteresis span the wake input must stay active
    wake_level = 8'h7D;
    repeat (10) @(negedge clk);
    chk({24'h0, sleeping_ff}, 25'h0);
    wake_level = 8'h7B;
    wslp(1, 10);
    low_power_mode = 1'b0;
    sleep_request  = 1'b0;
    wake_level     = 8'h00;
    $display("sleep done");
  end
  endtask

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    {fp_angle, fp_angle_valid, lp_angle, lp_angle_valid} = 26'h0;
    {low_power_mode, sleep_request, wake_level} = 10'h0;
    {count_source_select, turns_init, mode_180} = 4'h0;
    sleep_period_length = 16'h0003;
    counter_reset_cmd   = 1'b0;
    req_seen    = 1'b0;
    error_cnt   = 0;
    checks_done = 0;
    do_rst;
    t_track;
    t_paths;
    t_sleep;
    t_sat(1'b0, 25'h1800000);
    t_sat(1'b1, 25'h11FFFFF);
    conclude;
  end

  // watchdog at 40000 cycles, well above the expected run of about 8600
  initial
  begin
    #400000;
    error_cnt = error_cnt + 1;
    conclude;
  end
endmodule
